// ==== common/bsb_defs.svh ====
// constants of the branch, skip and bit unit: flag positions, reset values, cycle counts
// assumes it is included by bare name from design files
`ifndef BSB_DEFS_SVH
`define BSB_DEFS_SVH
// status flag bit positions
`define BSB_FLAG_C 0
`define BSB_FLAG_Z 1
`define BSB_FLAG_N 2
`define BSB_FLAG_V 3
`define BSB_FLAG_S 4
`define BSB_FLAG_H 5
`define BSB_FLAG_T 6
`define BSB_FLAG_I 7
// reset values
`define BSB_PC_RST    16'h0000
`define BSB_FLAGS_RST 8'h00
// last bit-addressable I/O register
`define BSB_IO_LAST   6'h1F
// execution cycle counts
`define BSB_CYC_ONE   3'h1
`define BSB_CYC_JUMP_Z 3'h2
`define BSB_CYC_CALL_Z 3'h3
`define BSB_CYC_EXIT   3'h4
`define BSB_CYC_BIT   3'h2
`define BSB_CYC_TAKEN 3'h2
`define BSB_CYC_SKIP1 3'h2
`define BSB_CYC_SKIP2 3'h3
`endif

// ==== common/bsb_pkg.sv ====
// types of the branch, skip and bit unit
// assumes the constants header is compiled alongside
package bsb_pkg;
  typedef enum logic [4:0] {
    OP_NOP                     = 5'b00000,
    OP_TEST_REGISTER           = 5'b00001,
    OP_INDIRECT_JUMP           = 5'b00010,
    OP_INDIRECT_CALL           = 5'b00011,
    OP_SUBROUTINE_EXIT         = 5'b00100,
    OP_INTERRUPT_EXIT          = 5'b00101,
    OP_COMPARE_SKIP_EQUAL      = 5'b00110,
    OP_COMPARE_IMMEDIATE       = 5'b00111,
    OP_SKIP_REG_BIT_CLEAR      = 5'b01000,
    OP_SKIP_REG_BIT_SET        = 5'b01001,
    OP_SKIP_IO_BIT_CLEAR       = 5'b01010,
    OP_SKIP_IO_BIT_SET         = 5'b01011,
    OP_BRANCH_STATUS_BIT_SET   = 5'b01100,
    OP_BRANCH_STATUS_BIT_CLEAR = 5'b01101,
    OP_BRANCH_SIGNED_GE        = 5'b01110,
    OP_BRANCH_SIGNED_LT        = 5'b01111,
    OP_BRANCH_UNSIGNED_HS      = 5'b10000,
    OP_BRANCH_UNSIGNED_LO      = 5'b10001,
    OP_BRANCH_IRQ_ON           = 5'b10010,
    OP_BRANCH_IRQ_OFF          = 5'b10011,
    OP_BRANCH_HALF_CARRY_SET   = 5'b10100,
    OP_BRANCH_HALF_CARRY_CLEAR = 5'b10101,
    OP_BRANCH_TFLAG_SET        = 5'b10110,
    OP_BRANCH_TFLAG_CLEAR      = 5'b10111,
    OP_BRANCH_OVERFLOW_SET     = 5'b11000,
    OP_BRANCH_OVERFLOW_CLEAR   = 5'b11001,
    OP_SET_IO_BIT              = 5'b11010,
    OP_CLEAR_IO_BIT            = 5'b11011,
    OP_ROTATE_LEFT_CARRY       = 5'b11100
  } bsb_op_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } bsb_state_type;
endpackage

// ==== hdl/bsb_flag_alu.sv ====
// flag arithmetic for test, compare-immediate and rotate
// purely combinational; caller registers the outputs
`timescale 1ns/100ps
`include "bsb_defs.svh"
module bsb_flag_alu (
  // operation and operands
  input  wire bsb_pkg::bsb_op_type op_i,
  input  wire logic [7:0]          a_i,
  input  wire logic [7:0]          b_i,
  input  wire logic [7:0]          flags_i,
  // results
  output logic      [7:0]          result_o,
  output logic                     write_o,
  output logic      [7:0]          flags_o
);
  logic [8:0] diff;
  logic       n;
  logic       v;

  always_comb begin
    diff     = {1'b0, a_i} - {1'b0, b_i};
    flags_o  = flags_i;
    result_o = a_i;
    write_o  = 1'b0;
    n        = 1'b0;
    v        = 1'b0;
    unique case (op_i)
      bsb_pkg::OP_TEST_REGISTER: begin
        n                   = a_i[7];
        flags_o[`BSB_FLAG_Z] = (a_i == 8'h00);
        flags_o[`BSB_FLAG_N] = n;
        flags_o[`BSB_FLAG_V] = 1'b0;
        flags_o[`BSB_FLAG_S] = n;
      end
      bsb_pkg::OP_COMPARE_IMMEDIATE: begin
        n = diff[7];
        v = (a_i[7] & ~b_i[7] & ~diff[7]) | (~a_i[7] & b_i[7] & diff[7]);
        flags_o[`BSB_FLAG_Z] = (diff[7:0] == 8'h00);
        flags_o[`BSB_FLAG_N] = n;
        flags_o[`BSB_FLAG_V] = v;
        flags_o[`BSB_FLAG_S] = n ^ v;
        flags_o[`BSB_FLAG_C] = diff[8];
        flags_o[`BSB_FLAG_H] = (~a_i[3] & b_i[3]) | (b_i[3] & diff[3]) | (diff[3] & ~a_i[3]);
      end
      bsb_pkg::OP_ROTATE_LEFT_CARRY: begin
        result_o = {a_i[6:0], flags_i[`BSB_FLAG_C]};
        write_o  = 1'b1;
        n        = a_i[6];
        v        = a_i[6] ^ a_i[7];
        flags_o[`BSB_FLAG_Z] = (result_o == 8'h00);
        flags_o[`BSB_FLAG_N] = n;
        flags_o[`BSB_FLAG_V] = v;
        flags_o[`BSB_FLAG_S] = n ^ v;
        flags_o[`BSB_FLAG_C] = a_i[7];
        flags_o[`BSB_FLAG_H] = a_i[3];
      end
      default: begin
        flags_o = flags_i;
      end
    endcase
  end
endmodule

// ==== hdl/bsb_branch_cond.sv ====
// branch condition evaluation from the status flags
// purely combinational
`timescale 1ns/100ps
`include "bsb_defs.svh"
module bsb_branch_cond (
  // operation
  input  wire bsb_pkg::bsb_op_type op_i,
  input  wire logic [2:0]          bit_sel_i,
  input  wire logic [7:0]          flags_i,
  // decision
  output logic                     taken_o
);
  always_comb begin
    taken_o = 1'b0;
    unique case (op_i)
      bsb_pkg::OP_BRANCH_STATUS_BIT_SET:   taken_o = flags_i[bit_sel_i];
      bsb_pkg::OP_BRANCH_STATUS_BIT_CLEAR: taken_o = ~flags_i[bit_sel_i];
      bsb_pkg::OP_BRANCH_SIGNED_GE:
        taken_o = ~(flags_i[`BSB_FLAG_N] ^ flags_i[`BSB_FLAG_V]);
      bsb_pkg::OP_BRANCH_SIGNED_LT:
        taken_o = flags_i[`BSB_FLAG_N] ^ flags_i[`BSB_FLAG_V];
      bsb_pkg::OP_BRANCH_UNSIGNED_HS:      taken_o = ~flags_i[`BSB_FLAG_C];
      bsb_pkg::OP_BRANCH_UNSIGNED_LO:      taken_o = flags_i[`BSB_FLAG_C];
      bsb_pkg::OP_BRANCH_IRQ_ON:           taken_o = flags_i[`BSB_FLAG_I];
      bsb_pkg::OP_BRANCH_IRQ_OFF:          taken_o = ~flags_i[`BSB_FLAG_I];
      bsb_pkg::OP_BRANCH_HALF_CARRY_SET:   taken_o = flags_i[`BSB_FLAG_H];
      bsb_pkg::OP_BRANCH_HALF_CARRY_CLEAR: taken_o = ~flags_i[`BSB_FLAG_H];
      bsb_pkg::OP_BRANCH_TFLAG_SET:        taken_o = flags_i[`BSB_FLAG_T];
      bsb_pkg::OP_BRANCH_TFLAG_CLEAR:      taken_o = ~flags_i[`BSB_FLAG_T];
      bsb_pkg::OP_BRANCH_OVERFLOW_SET:     taken_o = flags_i[`BSB_FLAG_V];
      bsb_pkg::OP_BRANCH_OVERFLOW_CLEAR:   taken_o = ~flags_i[`BSB_FLAG_V];
      default:                             taken_o = 1'b0;
    endcase
  end
endmodule

// ==== hdl/bsb_exec_unit.sv ====
// execution unit for control-flow, compare, skip and I/O bit instructions
// assumes decoded instructions, operands and I/O read data arrive on clk_i,
// presented combinationally by same-clock logic while instr_valid_i is high
//
// Notes on behaviour
// - test register sets Z N V, one cycle
// - indirect jump loads Z, two cycles
// - indirect call pushes return, loads Z, three
// - compare-skip equal skips next, 1/2/3 cycles
// - compare immediate updates flags, no writeback
// - skip when register bit clear
// - skip when register bit set
// - skip when I/O bit clear
// - skip when I/O bit set
// - status bit branch to PC+k+1, 1/2
// - signed branches use N xor V
// - unsigned branches use carry
// - interrupt branches use global enable
// - half-carry branches on H
// - T branches on T flag
// - overflow branches on V
// - set I/O bit, two cycles, flags kept
// - clear I/O bit, two cycles, flags kept
// - rotate left through carry, update flags
// - bit ops reach I/O 0x00-0x1F only
`timescale 1ns/100ps
`include "bsb_defs.svh"
module bsb_exec_unit #(
  parameter int PC_W = 16
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire logic                clk_en_i,
  // instruction
  input  wire logic                instr_valid_i,
  input  wire bsb_pkg::bsb_op_type op_i,
  input  wire logic [2:0]          bit_sel_i,
  input  wire logic [6:0]          offset_i,
  input  wire logic [7:0]          imm_i,
  input  wire logic [5:0]          io_addr_i,
  input  wire logic                next_long_i,
  // operands
  input  wire logic [7:0]          rd_val_i,
  input  wire logic [7:0]          rr_val_i,
  input  wire logic [PC_W-1:0]     z_ptr_i,
  input  wire logic [7:0]          io_rdata_i,
  input  wire logic [PC_W-1:0]     stack_data_i,
  // core state
  output logic      [PC_W-1:0]     pc_o,
  output logic      [7:0]          flags_o,
  output logic                     busy_o,
  output logic                     done_o,
  // register writeback
  output logic                     wr_en_o,
  output logic      [7:0]          wr_data_o,
  // I/O single-bit write
  output logic                     io_we_o,
  output logic      [4:0]          io_addr_o,
  output logic      [2:0]          io_bit_o,
  output logic                     io_bit_val_o,
  // stack
  output logic                     push_o,
  output logic      [PC_W-1:0]     push_data_o,
  output logic                     pop_o
);
  bsb_pkg::bsb_state_type state;
  logic [2:0]      cnt;
  logic            accept;
  logic [PC_W-1:0] next_pc;
  logic [2:0]      next_cycles;
  logic            skip;
  logic            io_ok;
  logic            is_branch;
  logic            taken;
  logic [7:0]      alu_result;
  logic            alu_write;
  logic [7:0]      alu_flags;

  // skip length depends on the size of the skipped instruction
  function automatic logic [2:0] skip_cycles(input logic long_next);
    skip_cycles = long_next ? `BSB_CYC_SKIP2 : `BSB_CYC_SKIP1;
  endfunction

  function automatic logic [PC_W-1:0] pc_plus(input logic [PC_W-1:0] pc,
                                             input logic [2:0]      inc);
    pc_plus = pc + {{(PC_W-3){1'b0}}, inc};
  endfunction

  assign accept = clk_en_i & instr_valid_i & (state == bsb_pkg::ST_IDLE);
  assign io_ok  = (io_addr_i <= `BSB_IO_LAST);

  bsb_flag_alu u_alu (
    .op_i     (op_i),
    .a_i      (rd_val_i),
    .b_i      (imm_i),
    .flags_i  (flags_o),
    .result_o (alu_result),
    .write_o  (alu_write),
    .flags_o  (alu_flags)
  );

  bsb_branch_cond u_cond (
    .op_i      (op_i),
    .bit_sel_i (bit_sel_i),
    .flags_i   (flags_o),
    .taken_o   (taken)
  );

  always_comb begin
    next_pc     = pc_plus(pc_o, `BSB_CYC_ONE);
    next_cycles = `BSB_CYC_ONE;
    skip        = 1'b0;
    is_branch   = 1'b0;
    unique case (op_i)
      bsb_pkg::OP_INDIRECT_JUMP: begin
        next_pc     = z_ptr_i;
        next_cycles = `BSB_CYC_JUMP_Z;
      end
      bsb_pkg::OP_INDIRECT_CALL: begin
        next_pc     = z_ptr_i;
        next_cycles = `BSB_CYC_CALL_Z;
      end
      bsb_pkg::OP_SUBROUTINE_EXIT,
      bsb_pkg::OP_INTERRUPT_EXIT: begin
        next_pc     = stack_data_i;
        next_cycles = `BSB_CYC_EXIT;
      end
      bsb_pkg::OP_COMPARE_SKIP_EQUAL: skip = (rd_val_i == rr_val_i);
      bsb_pkg::OP_SKIP_REG_BIT_CLEAR: skip = ~rr_val_i[bit_sel_i];
      bsb_pkg::OP_SKIP_REG_BIT_SET:   skip = rr_val_i[bit_sel_i];
      bsb_pkg::OP_SKIP_IO_BIT_CLEAR:  skip = io_ok & ~io_rdata_i[bit_sel_i];
      bsb_pkg::OP_SKIP_IO_BIT_SET:    skip = io_ok & io_rdata_i[bit_sel_i];
      bsb_pkg::OP_SET_IO_BIT,
      bsb_pkg::OP_CLEAR_IO_BIT: begin
        next_cycles = `BSB_CYC_BIT;
      end
      bsb_pkg::OP_BRANCH_STATUS_BIT_SET,
      bsb_pkg::OP_BRANCH_STATUS_BIT_CLEAR,
      bsb_pkg::OP_BRANCH_SIGNED_GE,
      bsb_pkg::OP_BRANCH_SIGNED_LT,
      bsb_pkg::OP_BRANCH_UNSIGNED_HS,
      bsb_pkg::OP_BRANCH_UNSIGNED_LO,
      bsb_pkg::OP_BRANCH_IRQ_ON,
      bsb_pkg::OP_BRANCH_IRQ_OFF,
      bsb_pkg::OP_BRANCH_HALF_CARRY_SET,
      bsb_pkg::OP_BRANCH_HALF_CARRY_CLEAR,
      bsb_pkg::OP_BRANCH_TFLAG_SET,
      bsb_pkg::OP_BRANCH_TFLAG_CLEAR,
      bsb_pkg::OP_BRANCH_OVERFLOW_SET,
      bsb_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
        is_branch = 1'b1;
      end
      bsb_pkg::OP_NOP,
      bsb_pkg::OP_TEST_REGISTER,
      bsb_pkg::OP_COMPARE_IMMEDIATE,
      bsb_pkg::OP_ROTATE_LEFT_CARRY: begin
        next_cycles = `BSB_CYC_ONE;
      end
      // unused codes behave as a no-op
      default: begin
        next_cycles = `BSB_CYC_ONE;
      end
    endcase
    if (is_branch && taken) begin
      next_pc     = pc_plus(pc_o, `BSB_CYC_ONE) + {{(PC_W-7){offset_i[6]}}, offset_i};
      next_cycles = `BSB_CYC_TAKEN;
    end
    if (skip) begin
      next_pc     = pc_plus(pc_o, skip_cycles(next_long_i));
      next_cycles = skip_cycles(next_long_i);
    end
  end

  // sequencing: busy holds off the next instruction
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state  <= bsb_pkg::ST_IDLE;
      cnt    <= 3'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (accept) begin
        if (next_cycles == `BSB_CYC_ONE) begin
          done_o <= 1'b1;
        end else begin
          state  <= bsb_pkg::ST_BUSY;
          busy_o <= 1'b1;
          cnt    <= next_cycles - 3'h2;
        end
      end else if (state == bsb_pkg::ST_BUSY) begin
        if (cnt == 3'h0) begin
          state  <= bsb_pkg::ST_IDLE;
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end
    end
  end

  // program counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_o <= `BSB_PC_RST;
    end else if (accept) begin
      pc_o <= next_pc;
    end
  end

  // status flags; control flow leaves them alone, except interrupt exit, which sets I
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_o <= `BSB_FLAGS_RST;
    end else if (accept) begin
      if (op_i == bsb_pkg::OP_INTERRUPT_EXIT) begin
        flags_o[`BSB_FLAG_I] <= 1'b1;
      end else begin
        flags_o <= alu_flags;
      end
    end
  end

  // register writeback, rotate only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_en_o   <= 1'b0;
      wr_data_o <= 8'h00;
    end else if (clk_en_i) begin
      wr_en_o   <= accept & alu_write;
      wr_data_o <= alu_result;
    end
  end

  // single-bit I/O write so neighbour flags are untouched
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      io_we_o      <= 1'b0;
      io_addr_o    <= 5'h00;
      io_bit_o     <= 3'h0;
      io_bit_val_o <= 1'b0;
    end else if (clk_en_i) begin
      io_we_o <= 1'b0;
      if (accept && io_ok && (op_i == bsb_pkg::OP_SET_IO_BIT ||
                              op_i == bsb_pkg::OP_CLEAR_IO_BIT)) begin
        io_we_o      <= 1'b1;
        io_addr_o    <= io_addr_i[4:0];
        io_bit_o     <= bit_sel_i;
        io_bit_val_o <= (op_i == bsb_pkg::OP_SET_IO_BIT);
      end
    end
  end

  // stack push and pop strobes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      push_o      <= 1'b0;
      push_data_o <= `BSB_PC_RST;
      pop_o       <= 1'b0;
    end else if (clk_en_i) begin
      push_o      <= accept & (op_i == bsb_pkg::OP_INDIRECT_CALL);
      push_data_o <= pc_plus(pc_o, `BSB_CYC_ONE);
      pop_o       <= accept & (op_i == bsb_pkg::OP_SUBROUTINE_EXIT ||
                               op_i == bsb_pkg::OP_INTERRUPT_EXIT);
    end
  end

  // checks; clock enable is held high by assumption, low aborts them
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i || !clk_en_i);

  sequence s_two_cycles;
    busy_o ##1 (done_o && !busy_o);
  endsequence

  sequence s_three_cycles;
    busy_o [*2] ##1 (done_o && !busy_o);
  endsequence

  a_test_reg_flags: assert property (
    accept && op_i == bsb_pkg::OP_TEST_REGISTER |=>
      done_o && !wr_en_o && flags_o[`BSB_FLAG_Z] == ($past(rd_val_i) == 8'h00)
      && !flags_o[`BSB_FLAG_V])
    else $error("test register flags or timing wrong");

  a_jump_z_target: assert property (
    accept && op_i == bsb_pkg::OP_INDIRECT_JUMP |=>
      pc_o == $past(z_ptr_i) && $stable(flags_o) ##0 s_two_cycles)
    else $error("indirect jump target or timing wrong");

  a_call_z_push: assert property (
    accept && op_i == bsb_pkg::OP_INDIRECT_CALL |=>
      push_o && push_data_o == $past(pc_o) + 1'b1 && pc_o == $past(z_ptr_i)
      ##0 s_three_cycles)
    else $error("indirect call push or timing wrong");

  a_skip_eq_long: assert property (
    accept && op_i == bsb_pkg::OP_COMPARE_SKIP_EQUAL && rd_val_i == rr_val_i
      && next_long_i |=> pc_o == $past(pc_o) + 3'h3 ##0 s_three_cycles)
    else $error("compare skip over long instruction wrong");

  a_cmp_imm_carry: assert property (
    accept && op_i == bsb_pkg::OP_COMPARE_IMMEDIATE |=>
      done_o && !wr_en_o && flags_o[`BSB_FLAG_C] == ($past(rd_val_i) < $past(imm_i)))
    else $error("compare immediate carry wrong");

  a_reg_clr_noskip: assert property (
    accept && op_i == bsb_pkg::OP_SKIP_REG_BIT_CLEAR && rr_val_i[bit_sel_i] |=>
      done_o && pc_o == $past(pc_o) + 1'b1)
    else $error("skip on clear taken when bit set");

  a_io_set_skip: assert property (
    accept && op_i == bsb_pkg::OP_SKIP_IO_BIT_SET && io_ok && io_rdata_i[bit_sel_i]
      && !next_long_i |=> pc_o == $past(pc_o) + 2'h2 ##0 s_two_cycles)
    else $error("skip on I/O set wrong");

  a_branch_taken: assert property (
    accept && is_branch && taken |=>
      pc_o == $past(pc_o) + 1'b1 + {{(PC_W-7){$past(offset_i[6])}}, $past(offset_i)}
      ##0 s_two_cycles)
    else $error("taken branch target or timing wrong");

  a_branch_ge: assert property (
    accept && op_i == bsb_pkg::OP_BRANCH_SIGNED_GE |=>
      busy_o == !($past(flags_o[`BSB_FLAG_N]) ^ $past(flags_o[`BSB_FLAG_V])))
    else $error("signed branch condition wrong");

  a_io_bit_write: assert property (
    accept && op_i == bsb_pkg::OP_SET_IO_BIT && io_ok |=>
      io_we_o && io_bit_val_o && io_bit_o == $past(bit_sel_i) && $stable(flags_o)
      ##0 s_two_cycles)
    else $error("set I/O bit wrong");

  a_io_range: assert property (
    accept && !io_ok |=> !io_we_o)
    else $error("I/O write beyond bit range");

  a_rotate_carry: assert property (
    accept && op_i == bsb_pkg::OP_ROTATE_LEFT_CARRY |=>
      wr_en_o && wr_data_o[0] == $past(flags_o[`BSB_FLAG_C])
      && flags_o[`BSB_FLAG_C] == $past(rd_val_i[7]))
    else $error("rotate through carry wrong");

  a_irq_exit_pop: assert property (
    accept && op_i == bsb_pkg::OP_INTERRUPT_EXIT |=>
      pop_o && flags_o[`BSB_FLAG_I] && pc_o == $past(stack_data_i)
      ##1 busy_o ##1 busy_o ##1 (done_o && !busy_o))
    else $error("interrupt return wrong");
endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the branch, skip and bit execution unit
// assumes the package and design sources are compiled first
`timescale 1ns/100ps
module tb_top;
  logic                clk_i, arst_n_i, clk_en_i, instr_valid_i, next_long_i;
  bsb_pkg::bsb_op_type op_i;
  logic [2:0]          bit_sel_i, io_bit_o;
  logic [6:0]          offset_i;
  logic [7:0]          imm_i, rd_val_i, rr_val_i, io_rdata_i, flags_o, wr_data_o;
  logic [5:0]          io_addr_i;
  logic [15:0]         z_ptr_i, stack_data_i, pc_o, push_data_o;
  logic                busy_o, done_o, wr_en_o, io_we_o, io_bit_val_o, push_o, pop_o;
  logic [4:0]          io_addr_o;
  int                  bad_count, checks, n;
  logic [3:0]          strb;
  logic                busy1;
  logic [15:0]         exp_pc, cap_push;
  logic [8:0]          cap_io;

  bsb_exec_unit #(.PC_W(16)) dut_u (
    .clk_i, .arst_n_i, .clk_en_i, .instr_valid_i, .op_i, .bit_sel_i, .offset_i,
    .imm_i, .io_addr_i, .next_long_i, .rd_val_i, .rr_val_i, .z_ptr_i, .io_rdata_i,
    .stack_data_i, .pc_o, .flags_o, .busy_o, .done_o, .wr_en_o, .wr_data_o, .io_we_o,
    .io_addr_o, .io_bit_o, .io_bit_val_o, .push_o, .push_data_o, .pop_o
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one instruction; valid stays up after a one-cycle op so the next goes back to back
  task automatic exec(input bsb_pkg::bsb_op_type op);
    op_i = op;
    if (instr_valid_i !== 1'b1)
      instr_valid_i = 1'b1;
    n = 0;
    strb = 4'h0;
    do begin
      @(negedge clk_i);
      n++;
      if (n == 1)
        busy1 = busy_o;
      // a held valid would restart the op in its done cycle
      if (n == 1 && done_o !== 1'b1)
        instr_valid_i = 1'b0;
      strb = strb | {push_o, pop_o, io_we_o, wr_en_o};
      if (push_o === 1'b1)
        cap_push = push_data_o;
      if (io_we_o === 1'b1)
        cap_io = {io_addr_o, io_bit_o, io_bit_val_o};
    end while (done_o !== 1'b1 && n < 8);
    if (done_o !== 1'b1) begin
      chk("done timeout", 0, 1);
      tally_and_finish();
    end
  endtask

  task automatic run(input bsb_pkg::bsb_op_type op, input int cyc, input logic [15:0] pce);
    exec(op);
    chk({op.name(), " cycles"}, n, cyc);
    chk({op.name(), " pc"}, pc_o, pce);
  endtask

  task automatic skp(input bsb_pkg::bsb_op_type op, input logic sk);
    exp_pc = exp_pc + (sk ? (next_long_i ? 16'h0003 : 16'h0002) : 16'h0001);
    run(op, sk ? (next_long_i ? 3 : 2) : 1, exp_pc);
  endtask

  task automatic t_flow();
    z_ptr_i = 16'h1234;
    run(bsb_pkg::OP_INDIRECT_JUMP, 2, 16'h1234);
    chk("jump flags", {busy1, flags_o}, {1'b1, 8'h00});
    z_ptr_i = 16'h0400;
    run(bsb_pkg::OP_INDIRECT_CALL, 3, 16'h0400);
    chk("call push", {strb[3], busy1, cap_push}, {2'b11, 16'h1235});
    stack_data_i = 16'h0222;
    run(bsb_pkg::OP_SUBROUTINE_EXIT, 4, 16'h0222);
    chk("exit pop", {strb[2], flags_o}, {1'b1, 8'h00});
    stack_data_i = 16'h0300;
    run(bsb_pkg::OP_INTERRUPT_EXIT, 4, 16'h0300);
    chk("irq exit flags", flags_o, 8'h80);
    $display("test flow done");
  endtask

  task automatic t_alu();
    rd_val_i = 8'h10;
    imm_i = 8'h20;
    run(bsb_pkg::OP_COMPARE_IMMEDIATE, 1, 16'h0301);
    chk("compare flags", {flags_o, strb[0]}, {8'h95, 1'b0});
    rd_val_i = 8'h00;
    run(bsb_pkg::OP_TEST_REGISTER, 1, 16'h0302);
    chk("test flags", {flags_o, strb[0]}, {8'h83, 1'b0});
    rd_val_i = 8'h81;
    run(bsb_pkg::OP_ROTATE_LEFT_CARRY, 1, 16'h0303);
    chk("rotate", {flags_o, strb[0], wr_data_o}, {8'h99, 1'b1, 8'h03});
    exp_pc = 16'h0303;
    $display("test alu done");
  endtask

  // flags here: I1 T0 H0 S1 V1 N0 Z0 C1
  task automatic t_branch();
    logic [15:0] tk;
    tk = 16'h1A6A;
    for (int i = 0; i < 14; i++) begin
      offset_i = i[0] ? 7'h7D : 7'h04;
      bit_sel_i = 3'(i + 1);
      exp_pc = exp_pc + 16'h0001 + (tk[i] ? {{9{offset_i[6]}}, offset_i} : 16'h0000);
      run(bsb_pkg::bsb_op_type'(bsb_pkg::OP_BRANCH_STATUS_BIT_SET + i), tk[i] ? 2 : 1,
          exp_pc);
    end
    chk("branch flags", flags_o, 8'h99);
    $display("test branch done");
  endtask

  task automatic t_skip();
    rd_val_i = 8'h5A;
    rr_val_i = 8'h5A;
    next_long_i = 1'b0;
    skp(bsb_pkg::OP_COMPARE_SKIP_EQUAL, 1'b1);
    next_long_i = 1'b1;
    skp(bsb_pkg::OP_COMPARE_SKIP_EQUAL, 1'b1);
    rr_val_i = 8'h5B;
    skp(bsb_pkg::OP_COMPARE_SKIP_EQUAL, 1'b0);
    rd_val_i = 8'h5B;
    io_rdata_i = 8'hA4;
    for (int b = 0; b < 8; b++) begin
      bit_sel_i = 3'(b);
      next_long_i = b[0];
      io_addr_i = 6'h1F - 6'(b);
      skp(bsb_pkg::OP_SKIP_REG_BIT_CLEAR, !rr_val_i[b]);
      skp(bsb_pkg::OP_SKIP_REG_BIT_SET, rr_val_i[b]);
      skp(bsb_pkg::OP_SKIP_IO_BIT_CLEAR, !io_rdata_i[b]);
      skp(bsb_pkg::OP_SKIP_IO_BIT_SET, io_rdata_i[b]);
    end
    // beyond the bit-addressable range the test never skips
    io_addr_i = 6'h20;
    bit_sel_i = 3'h2;
    skp(bsb_pkg::OP_SKIP_IO_BIT_SET, 1'b0);
    bit_sel_i = 3'h0;
    skp(bsb_pkg::OP_SKIP_IO_BIT_CLEAR, 1'b0);
    chk("skip flags", flags_o, 8'h99);
    $display("test skip done");
  endtask

  task automatic t_iobit();
    io_addr_i = 6'h1F;
    bit_sel_i = 3'h5;
    exp_pc = exp_pc + 16'h0001;
    run(bsb_pkg::OP_SET_IO_BIT, 2, exp_pc);
    chk("set bit", {strb[1], cap_io, flags_o}, {1'b1, 5'h1F, 3'h5, 1'b1, 8'h99});
    io_addr_i = 6'h03;
    bit_sel_i = 3'h0;
    exp_pc = exp_pc + 16'h0001;
    run(bsb_pkg::OP_CLEAR_IO_BIT, 2, exp_pc);
    chk("clear bit", {strb[1], cap_io, flags_o}, {1'b1, 5'h03, 3'h0, 1'b0, 8'h99});
    io_addr_i = 6'h20;
    exp_pc = exp_pc + 16'h0001;
    run(bsb_pkg::OP_SET_IO_BIT, 2, exp_pc);
    chk("out of range write", strb[1], 1'b0);
    $display("test io bit done");
  endtask

  // enable low freezes a call mid-way; a request while busy is ignored
  task automatic t_stall();
    z_ptr_i = 16'h0123;
    op_i = bsb_pkg::OP_INDIRECT_CALL;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    clk_en_i = 1'b0;
    op_i = bsb_pkg::OP_INDIRECT_JUMP;
    z_ptr_i = 16'h0777;
    repeat (3) @(negedge clk_i);
    chk("stall hold", {busy_o, done_o, pc_o}, {2'b10, 16'h0123});
    clk_en_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("stall resume", {busy_o, done_o, pc_o}, {2'b01, 16'h0123});
    instr_valid_i = 1'b0;
    $display("test stall done");
  endtask

  initial begin
    bad_count = 0;
    checks = 0;
    arst_n_i = 1'b0;
    clk_en_i = 1'b1;
    instr_valid_i = 1'b0;
    next_long_i = 1'b0;
    op_i = bsb_pkg::OP_NOP;
    bit_sel_i = 3'h0;
    offset_i = 7'h00;
    imm_i = 8'h00;
    io_addr_i = 6'h00;
    rd_val_i = 8'h00;
    rr_val_i = 8'h00;
    z_ptr_i = 16'h0000;
    io_rdata_i = 8'h00;
    stack_data_i = 16'h0000;
    repeat (5) @(negedge clk_i);
    chk("reset state", {pc_o, flags_o, busy_o, push_o, io_we_o}, {16'h0000, 8'h00, 3'h0});
    arst_n_i = 1'b1;
    t_flow();
    t_alu();
    t_branch();
    t_skip();
    t_iobit();
    t_stall();
    tally_and_finish();
  end
endmodule
